// ### decimation_filter_chain_test.sv
// decimation_filter_chain_test: self-checking bench for dfc_filter.
// assumes dfc_mod_model as modulator and a 10 MHz clock.
module decimation_filter_chain_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dfc_pkg::*;

  localparam int TMO = 80000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sync_req = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [23:0] result_data;
  logic conversion_done_n;
  logic [4:0] mod_data;
  logic signed [4:0] level = '0;
  logic [31:0] d;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int lat, l0, n, x, i, k, tot;

  dfc_filter dut (.clk(clk), .rst_n(rst_n), .mod_data(mod_data),
    .sync_req(sync_req), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .result_data(result_data),
    .conversion_done_n(conversion_done_n));
  dfc_mod_model model (.clk(clk), .rst_n(rst_n), .level(level),
    .mod_data(mod_data));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc >= TMO) begin
      n_mismatch++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  // cycles until the next falling edge of done, bounded
  task automatic fall(input int lim, output int c);
    logic last;
    last = conversion_done_n;
    c = 0;
    while (1) begin
      @(posedge clk);
      #1 c++;
      if (conversion_done_n === 1'b0 && last === 1'b1) break;
      last = conversion_done_n;
      if (c >= lim) begin
        check(1'b0, "no conversion");
        break;
      end
    end
  endtask

  // new level and configuration, then first published result
  task automatic start(input logic [31:0] c, input int xv, input int lim,
                       output int l);
    @(posedge clk);
    level <= 5'(xv);
    wr(REG_CTRL, c);
    fall(lim, l);
  endtask

  function automatic logic [31:0] cfg(input int m, input int o, input int s,
                                     input int b);
    return 32'(m) | (32'(o) << CTRL_OSR_LSB) | (32'(s) << CTRL_S1_LSB)
      | (32'(b) << CTRL_BUF_BIT);
  endfunction

  // full scale is a word of 16, so one step of level is 2**19
  function automatic bit near(input logic [23:0] r, input int xv,
                              input int dr);
    int e;
    e = int'($signed(r)) - xv * 524288;
    return (^r !== 1'bx) && e <= 256 + (1 << dr) && e >= -256 - (1 << dr);
  endfunction

  function automatic int drop_of(input int c);
    return c < N_LOWRES ? DROP_TAB[c] : 0;
  endfunction

  function automatic int rnd_level();
    return int'($urandom_range(30)) - 15;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h3df7_de50));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 check(rdata === 32'h0000_0000 && conversion_done_n === 1'b1, "reset");
    rd(REG_CTRL, d);
    check(d === CTRL_RST, "ctrl reset value");
    rd(8'h10, d);
    check(d === 32'h0000_0000, "unmapped read");
    wr(REG_STATUS, 32'hffff_ffff);
    rd(REG_STATUS, d);
    check(d === 32'h0000_0000, "status write not ignored");
    for (i = 0; i < 6; i++) begin
      x = rnd_level();
      start(cfg(1, i, 0, 0), x, 16 * OSR4_TAB[i] + 64, lat);
      check(lat >= 6 * OSR4_TAB[i], "sinc4 early result");
      check(near(result_data, x, drop_of(i)), "sinc4 value");
      check((result_data & 24'((1 << drop_of(i)) - 1)) === 24'h00_0000,
            "low bits set");
      fall(4 * OSR4_TAB[i], n);
      check(n == 2 * OSR4_TAB[i], "sinc4 period");
      rd(REG_DATA, d);
      check(d[31:24] === {8{d[23]}} && near(d[23:0], x, drop_of(i)),
            "data register");
    end
    for (k = 0; k < 2; k++) begin
      x = rnd_level();
      start(cfg(1 - k, k * 3, 0, 0), x, 6000, l0);
      // restart keeps the modulator phase: land both syncs on one phase
      if (l0 % 2 == 0) @(posedge clk);
      start(cfg(1 - k, k * 3, 0, 1), x, 6000, lat);
      check(lat == l0 + BUF_CYC, "buffer latency");
      check(near(result_data, x, 5), "settled first result");
      if (k == 1)
        check(l0 >= 67 * 64 && l0 <= 70 * 64 + 16,
              "wideband latency");
    end
    for (k = 0; k < 2; k++) begin
      start(cfg(k, 3, 0, 0), rnd_level(), 6000, lat);
      x = rnd_level();
      @(posedge clk);
      level <= 5'(x);
      tot = 0;
      repeat (k ? 5 : 70) begin
        fall(200, n);
        tot += n;
      end
      check(tot == (k ? 5 : 70) * 64 - 1,
            "results withheld");
      check(near(result_data, x, 5), "step not settled");
    end
    start(cfg(1, 0, 0, 0), rnd_level(), 400, lat);
    rd(REG_STATUS, d);
    check(d[STAT_RUN_BIT] === 1'b1, "not running");
    x = rnd_level();
    @(posedge clk);
    level <= 5'(x);
    sync_req <= 1'b1;
    repeat (4) @(posedge clk);
    sync_req <= 1'b0;
    fall(400, n);
    check(n >= 70 && near(result_data, x, 5), "sync pin restart");
    wr(REG_SYNC, 32'h0000_0000);
    rd(REG_STATUS, d);
    check(d[STAT_RUN_BIT] === 1'b0, "sync write kept state");
    fall(400, n);
    check(n >= 70 && near(result_data, x, 5), "sync write restart");
    for (i = 0; i < 4; i++) begin
      x = rnd_level();
      start(cfg(2, 0, i, 0), x, 128 * S1_4_TAB[i] + 600, lat);
      fall(128 * S1_4_TAB[i], n);
      check(n == 64 * S1_4_TAB[i], "cascade period");
      check(near(result_data, x, 5), "cascade value");
    end
    for (k = 0; k < 4; k++) begin
      wr(REG_CTRL, cfg(3 + k / 2, k % 2, k % 2, 0));
      rd(REG_CTRL, d);
      check(d === cfg(3 + k / 2, k % 2, k % 2, 0),
            "sinc3 config");
    end
    give_verdict();
  end
endmodule

// ### dfc_filter.sv
// dfc_filter: decimating filter chain behind a delta-sigma modulator,
// wideband and four sinc configurations, with its register port.
// assumes mod_data is produced on clk; sync_req is an asynchronous pin.
// Behaviour
// - output rate is modulator rate divided by the selected ratio
// - two filter families: wideband and low-latency
// - wideband ratios 32 to 4096 in powers of two
// - wideband output delayed a constant 34 output periods
// - every sync clears all accumulated filter state
// - wideband withholds the first 68 conversion periods after restart
// - wideband first result after 69 periods plus 0.4 us overhead
// - wideband input step without sync: results keep flowing
// - input buffers enabled add 8 device clock periods of latency
// - sinc4, sinc4+sinc1, sinc3 and sinc3+sinc1 configurations
// - sinc modes suppress unsettled results; done falls on first settled
// - sinc input change without sync: partial results, no suppression
// - modulator samples taken at half the device clock
// - sinc4 ratios 12, 16, 24 and 32 to 4096
// - sinc4 low ratios give 19, 21 and 23 bits
// - sinc4+sinc1: first stage fixed 32, second stage 2 to 1000
// - sinc3 ratios 26667 and 32000
// - sinc3+sinc1: first stage 32000, second stage 3 or 5
// - single-stage sinc bypasses the second averaging stage
//
// Implementation choices: the plain strobed port and the address map.
module dfc_filter #(
  parameter int QW = 5,
  parameter int OUT_W = 24,
  parameter int ACC_W = 56,
  parameter int DONE_LOW_CYC = 2
) (
  input logic clk,
  input logic rst_n,
  input logic [QW-1:0] mod_data,
  input logic sync_req,
  input logic [dfc_pkg::ADDR_W-1:0] addr,
  input logic [31:0] wdata,
  input logic wr_en,
  input logic rd_en,
  output logic [31:0] rdata,
  output logic [OUT_W-1:0] result_data,
  output logic conversion_done_n
);
  import dfc_pkg::*;

  localparam int FW = ACC_W + 10;
  localparam int PW = FW + 33;

  if (ACC_W < QW + 48) begin : g_acc_chk
    $error("accumulator narrower than sinc4 growth at ratio 4096");
  end
  if (OUT_W < 8 || OUT_W > 31 || QW < 2) begin : g_width_chk
    $error("output or modulator width not supported");
  end
  if (DONE_LOW_CYC < 1 || DONE_LOW_CYC > 15) begin : g_low_chk
    $error("done pulse must last 1 to 15 cycles");
  end

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic mod_ph;
    logic [31:0] ctrl;
    logic [3:0][ACC_W-1:0] integ;
    logic [3:0][ACC_W-1:0] dly;
    logic [14:0] dec_cnt;
    logic [2:0] st1_cnt;
    logic [FW-1:0] acc2;
    logic [9:0] s2_cnt;
    logic [6:0] sup_cnt;
    logic [WB_DELAY-1:0][OUT_W-1:0] line;
    logic [5:0] wr_ptr;
    logic [OUT_W-1:0] hold;
    logic [3:0] pend;
    logic [3:0] low_cnt;
    logic done_n;
    logic [OUT_W-1:0] result;
    logic [31:0] rdata;
    dfc_phase_t phase;
  } dfc_state_t;

  dfc_state_t st_reg, st_next;
  dfc_mode_t mode;
  logic [3:0] osr_c, s1_c;
  logic [14:0] a_cur;
  logic [9:0] b_cur;
  logic [2:0] drop;
  logic [31:0] mant;
  logic [6:0] shf;
  logic ord4, is_wb, single, buf_en;
  logic restart, conv_load, mod_tick, fin, st1_ok, wr_ctrl;
  logic [ACC_W-1:0] v, t;
  logic [FW-1:0] fval, sum;
  logic signed [PW-1:0] prod, sh;
  logic [OUT_W-1:0] word, outw;

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode; gains are folded per table entry, no divider
  always_comb begin
    mode = dfc_mode_t'(st_reg.ctrl[CTRL_MODE_LSB +: 3]);
    osr_c = st_reg.ctrl[CTRL_OSR_LSB +: 4];
    s1_c = st_reg.ctrl[CTRL_S1_LSB +: 4];
    buf_en = st_reg.ctrl[CTRL_BUF_BIT];
    is_wb = 1'b0;
    single = 1'b1;
    ord4 = 1'b1;
    drop = 3'h0;
    b_cur = 10'h001;
    a_cur = 15'(SINC4_FIX_OSR);
    {mant, shf} = f_norm(f_gain(SINC4_FIX_OSR, 4, 1), OUT_W, QW);
    case (mode)
      FM_SINC4: begin
        for (int i = 0; i < N_OSR4; i++) begin
          if (osr_c == 4'(i)) begin
            a_cur = 15'(OSR4_TAB[i]);
            {mant, shf} = f_norm(f_gain(OSR4_TAB[i], 4, 1), OUT_W, QW);
            if (i < N_LOWRES) begin
              drop = 3'(DROP_TAB[i]);
            end
          end
        end
      end
      FM_SINC4_SINC1: begin
        single = 1'b0;
        for (int i = 0; i < N_S1_4; i++) begin
          if (s1_c == 4'(i)) begin
            b_cur = 10'(S1_4_TAB[i]);
            {mant, shf} = f_norm(f_gain(SINC4_FIX_OSR, 4, S1_4_TAB[i]),
                                 OUT_W, QW);
          end
        end
      end
      FM_SINC3: begin
        ord4 = 1'b0;
        for (int i = 0; i < 2; i++) begin
          if (osr_c[0] == 1'(i)) begin
            a_cur = 15'(OSR3_TAB[i]);
            {mant, shf} = f_norm(f_gain(OSR3_TAB[i], 3, 1), OUT_W, QW);
          end
        end
      end
      FM_SINC3_SINC1: begin
        ord4 = 1'b0;
        single = 1'b0;
        a_cur = 15'(SINC3_FIX_OSR);
        for (int i = 0; i < 2; i++) begin
          if (s1_c[0] == 1'(i)) begin
            b_cur = 10'(S1_3_TAB[i]);
            {mant, shf} = f_norm(f_gain(SINC3_FIX_OSR, 3, S1_3_TAB[i]),
                                 OUT_W, QW);
          end
        end
      end
      default: begin
        // wideband; codes below 3 fall back to 32
        is_wb = 1'b1;
        for (int i = WB_MIN_CODE; i < N_OSR4; i++) begin
          if (osr_c == 4'(i)) begin
            a_cur = 15'(OSR4_TAB[i]);
            {mant, shf} = f_norm(f_gain(OSR4_TAB[i], 4, 1), OUT_W, QW);
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    fin = 1'b0;
    st1_ok = 1'b0;
    conv_load = 1'b0;
    v = '0;
    t = '0;
    fval = '0;
    sum = '0;
    st_next.s1 = sync_req;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    mod_tick = st_reg.mod_ph;
    st_next.mod_ph = ~st_reg.mod_ph;
    wr_ctrl = wr_en && addr == REG_CTRL;
    // a config write restarts too: old state belongs to another gain
    restart = (st_reg.s2 && !st_reg.s3) ||
              (wr_en && (addr == REG_CTRL || addr == REG_SYNC));

    st_next.rdata = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        REG_CTRL: st_next.rdata = st_reg.ctrl;
        REG_STATUS: begin
          st_next.rdata[STAT_RUN_BIT] = st_reg.phase == PH_RUN;
          st_next.rdata[STAT_DONE_BIT] = ~st_reg.done_n;
        end
        REG_DATA: st_next.rdata = 32'($signed(st_reg.result));
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_ctrl) begin
      st_next.ctrl = wdata;
    end

    // integrators wrap modulo 2**ACC_W; the combs undo the wrap
    if (mod_tick) begin
      st_next.integ[0] = st_reg.integ[0] + ACC_W'($signed(mod_data));
      for (int k = 1; k < 4; k++) begin
        st_next.integ[k] = st_reg.integ[k] + st_next.integ[k - 1];
      end
      if (st_reg.dec_cnt >= a_cur - 15'h1) begin
        st_next.dec_cnt = '0;
        v = ord4 ? st_next.integ[3] : st_next.integ[2];
        for (int k = 0; k < 4; k++) begin
          if (k < 3 || ord4) begin
            t = v - st_reg.dly[k];
            st_next.dly[k] = v;
            v = t;
          end
        end
        // only a restart re-arms suppression, so a later input
        // step yields partially settled words
        st1_ok = st_reg.st1_cnt >= (ord4 ? 3'h3 : 3'h2);
        if (!st1_ok) begin
          st_next.st1_cnt = st_reg.st1_cnt + 3'h1;
        end
        if (is_wb || (st1_ok && single)) begin
          fin = 1'b1;
          fval = FW'($signed(v));
        end else if (st1_ok) begin
          sum = st_reg.acc2 + FW'($signed(v));
          if (st_reg.s2_cnt >= b_cur - 10'h1) begin
            fin = 1'b1;
            fval = sum;
            st_next.acc2 = '0;
            st_next.s2_cnt = '0;
          end else begin
            st_next.acc2 = sum;
            st_next.s2_cnt = st_reg.s2_cnt + 10'h1;
          end
        end
      end else begin
        st_next.dec_cnt = st_reg.dec_cnt + 15'h1;
      end
    end

    // scale to full width, saturate, clear bits below the resolution
    prod = $signed(fval) * $signed({1'b0, mant});
    sh = prod >>> shf;
    if (&sh[PW-1:OUT_W-1] || ~|sh[PW-1:OUT_W-1]) begin
      word = sh[OUT_W-1:0];
    end else begin
      word = {sh[PW-1], {(OUT_W-1){~sh[PW-1]}}};
    end
    word = word & ({OUT_W{1'b1}} << drop);

    outw = word;
    if (fin && is_wb) begin
      outw = st_reg.line[st_reg.wr_ptr];
      st_next.line[st_reg.wr_ptr] = word;
      st_next.wr_ptr = (st_reg.wr_ptr == 6'(WB_DELAY - 1)) ? 6'h0 :
                       st_reg.wr_ptr + 6'h1;
      if (st_reg.sup_cnt < 7'(WB_SETTLE)) begin
        st_next.sup_cnt = st_reg.sup_cnt + 7'h1;
      end
    end
    // once settled, wideband words flow on whatever the input does
    conv_load = fin && (!is_wb || st_reg.sup_cnt == 7'(WB_SETTLE));

    if (!st_reg.done_n) begin
      if (st_reg.low_cnt == 4'h0) begin
        st_next.done_n = 1'b1;
      end else begin
        st_next.low_cnt = st_reg.low_cnt - 4'h1;
      end
    end
    if (st_reg.pend != 4'h0) begin
      st_next.pend = st_reg.pend - 4'h1;
      if (st_reg.pend == 4'h1 && !restart) begin
        st_next.result = st_reg.hold;
        st_next.done_n = 1'b0;
        st_next.low_cnt = 4'(DONE_LOW_CYC - 1);
      end
    end
    if (conv_load) begin
      st_next.hold = outw;
      st_next.pend = (is_wb ? 4'(OVH_CYC) : 4'h1) +
                     (buf_en ? 4'(BUF_CYC) : 4'h0);
      st_next.phase = PH_RUN;
    end

    if (restart) begin
      st_next.integ = '0;
      st_next.dly = '0;
      st_next.dec_cnt = '0;
      st_next.st1_cnt = '0;
      st_next.acc2 = '0;
      st_next.s2_cnt = '0;
      st_next.sup_cnt = '0;
      st_next.line = '0;
      st_next.wr_ptr = '0;
      st_next.pend = '0;
      st_next.phase = PH_SETTLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RST;
      st_reg.done_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign result_data = st_reg.result;
  assign conversion_done_n = st_reg.done_n;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_dec_bound;
    st_reg.dec_cnt < a_cur;
  endproperty
  a_dec_bound: assert property (p_dec_bound)
    else $error("decimation count beyond ratio");

  property p_mod_rate;
    (!st_reg.mod_ph && !restart) |=> $stable(st_reg.integ);
  endproperty
  a_mod_rate: assert property (p_mod_rate)
    else $error("integrators moved off the modulator phase");

  property p_restart;
    restart |=> (st_reg.integ == '0 && st_reg.sup_cnt == '0 &&
                 st_reg.pend == 4'h0 && st_reg.phase == PH_SETTLE);
  endproperty
  a_restart: assert property (p_restart)
    else $error("filter state survived a restart");

  property p_wb_suppress;
    (conv_load && is_wb) |-> st_reg.sup_cnt == 7'(WB_SETTLE);
  endproperty
  a_wb_suppress: assert property (p_wb_suppress)
    else $error("wideband result before settling count");

  property p_wb_latency;
    disable iff (!rst_n || restart)
    (conv_load && is_wb && !buf_en) |-> ##5 $fell(conversion_done_n);
  endproperty
  a_wb_latency: assert property (p_wb_latency)
    else $error("wideband overhead not four cycles");

  property p_buf_latency;
    disable iff (!rst_n || restart)
    (conv_load && !is_wb && buf_en) |-> ##10 $fell(conversion_done_n);
  endproperty
  a_buf_latency: assert property (p_buf_latency)
    else $error("buffer latency not eight extra cycles");

  property p_sinc_settled;
    (conv_load && !is_wb) |-> st_reg.st1_cnt == (ord4 ? 3'h3 : 3'h2);
  endproperty
  a_sinc_settled: assert property (p_sinc_settled)
    else $error("unsettled sinc result released");

  property p_bypass;
    single |-> (st_reg.s2_cnt == 10'h000 && st_reg.acc2 == '0);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("second stage active in single-stage mode");

  property p_cascade4;
    mode == FM_SINC4_SINC1 |-> a_cur == 15'h0020;
  endproperty
  a_cascade4: assert property (p_cascade4)
    else $error("cascade first stage not 32");

  property p_cascade3;
    mode == FM_SINC3_SINC1 |->
      a_cur == 15'(SINC3_FIX_OSR) && (b_cur == 10'h003 || b_cur == 10'h005);
  endproperty
  a_cascade3: assert property (p_cascade3)
    else $error("sinc3 cascade ratios wrong");

  property p_lowres;
    ($fell(conversion_done_n) && mode == FM_SINC4 && osr_c == 4'h0) |->
      st_reg.result[4:0] == 5'h00;
  endproperty
  a_lowres: assert property (p_lowres)
    else $error("low bits not cleared at ratio 12");

  c_wb_result: cover property (conv_load && is_wb);
  c_sinc4_low: cover property ($fell(conversion_done_n) && osr_c == 4'h0 &&
                               mode == FM_SINC4);
  c_cascade3: cover property (conv_load && mode == FM_SINC3_SINC1);
  c_pin_sync: cover property (st_reg.s2 && !st_reg.s3);

endmodule

// ### dfc_mod_model.sv
// dfc_mod_model: behavioural stand-in for the delta-sigma modulator.
// assumes the bench sets the wanted level; words follow clk.
module dfc_mod_model #(
  parameter int QW = 5
) (
  input logic clk,
  input logic rst_n,
  input logic signed [QW-1:0] level,
  output logic [QW-1:0] mod_data
);
  logic phase_reg;

  ////////////////////////////////////////////////////////////////////////////
  // no dither: a constant word keeps expected results exact, at the cost
  // of never exercising idle tones
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_reg <= 1'b0;
      mod_data <= '0;
    end else begin
      phase_reg <= ~phase_reg;
      if (!phase_reg) begin
        mod_data <= level;
      end
    end
  end
endmodule

// ### dfc_pkg.sv
// dfc_pkg: register map, mode codes, ratio tables and timing constants
// for the decimation filter chain.
// assumes a 10 MHz core clock and one modulator word every second cycle.
package dfc_pkg;

  typedef enum logic [2:0] {
    FM_WIDEBAND,
    FM_SINC4,
    FM_SINC4_SINC1,
    FM_SINC3,
    FM_SINC3_SINC1
  } dfc_mode_t;

  typedef enum logic {
    PH_SETTLE,
    PH_RUN
  } dfc_phase_t;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SYNC = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OSR_LSB = 4;
  localparam int CTRL_S1_LSB = 8;
  localparam int CTRL_BUF_BIT = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0030;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_NS = 100;
  localparam int OVH_NS = 400;
  localparam int OVH_CYC = (OVH_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUF_CYC = 8;
  localparam int WB_SETTLE = 68;
  localparam int WB_DELAY = 34;
  localparam int WB_MIN_CODE = 3;
  localparam int SINC4_FIX_OSR = 32;
  localparam int SINC3_FIX_OSR = 32000;
  localparam int N_OSR4 = 11;
  localparam int N_S1_4 = 9;
  localparam int N_LOWRES = 3;
  localparam int OSR4_TAB [N_OSR4] =
    '{12, 16, 24, 32, 64, 128, 256, 512, 1024, 2048, 4096};
  localparam int S1_4_TAB [N_S1_4] =
    '{2, 4, 10, 20, 40, 100, 200, 400, 1000};
  localparam int OSR3_TAB [2] = '{26667, 32000};
  localparam int S1_3_TAB [2] = '{3, 5};
  localparam int DROP_TAB [N_LOWRES] = '{5, 3, 1};

  ////////////////////////////////////////////////////////////////////////////
  // total dc gain of a configuration: a**n * b
  function automatic logic [63:0] f_gain(input int a, input int n,
                                         input int b);
    logic [63:0] g;
    g = 64'(b);
    for (int i = 0; i < n; i++) begin
      g = g * 64'(a);
    end
    return g;
  endfunction

  // {mantissa, shift} so that (acc * mantissa) >>> shift is full scale
  function automatic logic [38:0] f_norm(input logic [63:0] g, input int ow,
                                         input int qw);
    logic [127:0] num;
    logic [31:0] m;
    num = 128'h1 << ($clog2(g) + ow - 1);
    m = 32'(num / {64'h0, g});
    return {m, 7'($clog2(g) + qw - 1)};
  endfunction

endpackage
